// file: design/two_wire_consts.vh
/*
 Constants of the two-wire slave engine: register offsets, control bit
 positions, reset values, status codes and bus timing.
 Assumes inclusion by bare name from design files that use them.
*/
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH

`define OFS_OWN_ADDR     3'h0
`define OFS_CONTROL      3'h1
`define OFS_STATUS       3'h2
`define OFS_DATA         3'h3

`define BIT_FLAG         7
`define BIT_ACK_EN       6
`define BIT_START_REQ    5
`define BIT_STOP_REQ     4
`define BIT_WCOL         3
`define BIT_ENABLE       2
`define BIT_INT_EN       0

`define RST_OWN_ADDR     8'h00
`define RST_DATA         8'hff
`define RST_PRESCALE     2'h0

`define ST_BUS_ERROR     8'h00
`define ST_OWN_W         8'h60
`define ST_LOST_OWN_W    8'h68
`define ST_GC            8'h70
`define ST_LOST_GC       8'h78
`define ST_RX_ACK        8'h80
`define ST_RX_NACK       8'h88
`define ST_GC_RX_ACK     8'h90
`define ST_GC_RX_NACK    8'h98
`define ST_STOP_RESTART  8'ha0
`define ST_OWN_R         8'ha8
`define ST_LOST_OWN_R    8'hb0
`define ST_TX_ACK        8'hb8
`define ST_TX_NACK       8'hc0
`define ST_LAST_ACK      8'hc8
`define ST_NO_INFO       8'hf8
`define CODE_NO_INFO     5'h1f

`define GC_ADDRESS       7'h00
`define START_HOLD_NS    4000
`define CLK_MHZ          100

`endif

// file: design/line_sampler.v
/*
 Samples the serial clock and data lines into the system clock domain and
 reports clock edges and START and STOP conditions as one-cycle pulses.
 Assumes both lines arrive asynchronously from the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module line_sampler (
   input  wire clk,
   input  wire reset_n,
   input  wire scl_pin,
   input  wire sda_pin,
   output wire scl,
   output wire sda,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_seen,
   output wire stop_seen
);
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg       scl_prev;
   reg       sda_prev;

   // Idle bus is high, so the pipeline resets high
   always @(posedge clk) begin
      if (!reset_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_pin};
         sda_sync <= {sda_sync[0], sda_pin};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   assign scl        = scl_sync[1];
   assign sda        = sda_sync[1];
   assign scl_rise   = scl_sync[1] & ~scl_prev;
   assign scl_fall   = ~scl_sync[1] & scl_prev;
   assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
   assign stop_seen  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
endmodule

`default_nettype wire

// file: design/two_wire_slave_engine.v
/*
 Slave engine of a byte-oriented two-wire serial bus: address match,
 receive and transmit byte handling, status posting, clock stretching,
 sleep wake-up and the START request after leaving the addressed state.
 Assumes lines are open drain with pull-ups outside, and that master
 logic elsewhere reports lost arbitration and takes over after a START.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`include "two_wire_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_engine (
   input  wire       clk,
   input  wire       reset_n,
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe,
   input  wire       arbitration_lost,
   input  wire       sleep_active,
   output wire       wake_request,
   output reg        start_issued
);
   localparam START_HOLD_CYC = (`START_HOLD_NS * `CLK_MHZ + 999) / 1000;
   localparam S_IDLE  = 4'h0;
   localparam S_ADDR  = 4'h1;
   localparam S_AACK  = 4'h2;
   localparam S_RX    = 4'h3;
   localparam S_RACK  = 4'h4;
   localparam S_TX    = 4'h5;
   localparam S_TACK  = 4'h6;
   localparam S_HOLD  = 4'h7;
   localparam S_ERR   = 4'h8;
   localparam S_START = 4'h9;
   wire scl;
   wire sda;
   wire scl_rise;
   wire scl_fall;
   wire start_seen;
   wire stop_seen;
   line_sampler u_lines (
      .clk        (clk),
      .reset_n    (reset_n),
      .scl_pin    (scl_in),
      .sda_pin    (sda_in),
      .scl        (scl),
      .sda        (sda),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .start_seen (start_seen),
      .stop_seen  (stop_seen)
   );
   reg  [7:0] own_slave_address;
   reg        interrupt_flag;
   reg        acknowledge_enable;
   reg        start_request;
   reg        stop_request;
   reg        write_collision_flag;
   reg        interface_enable;
   reg        interrupt_enable;
   reg  [7:0] status;
   reg  [1:0] prescale;
   reg  [7:0] two_wire_data;
   reg  [3:0] state;
   reg  [7:0] shreg;
   reg  [3:0] cnt;
   reg        is_gc;
   reg        is_tx;
   reg        last;
   reg        nack;
   reg        lost_arb;
   reg        busy;
   reg        start_pend;
   reg        woke;
   reg        sda_low;
   reg [11:0] start_cnt;
   // Status codes after which the engine falls back to not addressed
   function leaves_addressed;
      input [7:0] code;
      begin
         leaves_addressed = (code == `ST_RX_NACK) || (code == `ST_GC_RX_NACK) ||
                            (code == `ST_STOP_RESTART) || (code == `ST_TX_NACK) ||
                            (code == `ST_LAST_ACK);
      end
   endfunction
   wire ctl_wr    = reg_wr && (reg_addr == `OFS_CONTROL);
   wire clear_req = ctl_wr && reg_wdata[`BIT_FLAG] && interrupt_flag;
   wire in_frame  = (state == S_ADDR) || (state == S_AACK) || (state == S_RX) ||
                    (state == S_RACK) || (state == S_TX) || (state == S_TACK);
   wire own_hit   = (shreg[7:1] == own_slave_address[7:1]);
   wire gc_hit    = (shreg[7:1] == `GC_ADDRESS) && !shreg[0] &&
                    own_slave_address[0];
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   // The 0xA0 post comes with SCL high, so it is never stretched
   assign scl_oe  = (state == S_HOLD) && interrupt_flag &&
                    (status != `ST_STOP_RESTART);
   assign sda_oe  = sda_low;
   assign wake_request = woke && interrupt_flag;
   always @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_OWN_ADDR: reg_rdata <= own_slave_address;
            `OFS_CONTROL:  reg_rdata <= {interrupt_flag, acknowledge_enable,
                                         start_request, stop_request,
                                         write_collision_flag, interface_enable,
                                         1'b0, interrupt_enable};
            // Code and prescaler share the byte; code bit 2 reads zero
            `OFS_STATUS:   reg_rdata <= {(interrupt_flag ? status[7:3] :
                                          `CODE_NO_INFO), 1'b0, prescale};
            `OFS_DATA:     reg_rdata <= two_wire_data;
            default:       reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
   always @(posedge clk) begin
      if (!reset_n) begin
         own_slave_address    <= `RST_OWN_ADDR;
         interrupt_flag       <= 1'b0;
         acknowledge_enable   <= 1'b0;
         start_request        <= 1'b0;
         stop_request         <= 1'b0;
         write_collision_flag <= 1'b0;
         interface_enable     <= 1'b0;
         interrupt_enable     <= 1'b0;
         status               <= `ST_NO_INFO;
         prescale             <= `RST_PRESCALE;
         two_wire_data        <= `RST_DATA;
         state                <= S_IDLE;
         shreg                <= 8'h00;
         cnt                  <= 4'h0;
         is_gc                <= 1'b0;
         is_tx                <= 1'b0;
         last                 <= 1'b0;
         nack                 <= 1'b0;
         lost_arb             <= 1'b0;
         busy                 <= 1'b0;
         start_pend           <= 1'b0;
         woke                 <= 1'b0;
         sda_low              <= 1'b0;
         start_cnt            <= 12'h000;
         start_issued         <= 1'b0;
      end else begin
         start_issued <= 1'b0;
         // Register writes first; hardware updates below win the same cycle
         if (reg_wr && (reg_addr == `OFS_OWN_ADDR))
            own_slave_address <= reg_wdata;
         if (reg_wr && (reg_addr == `OFS_STATUS))
            prescale <= reg_wdata[1:0];
         if (reg_wr && (reg_addr == `OFS_DATA)) begin
            if (interrupt_flag) begin
               two_wire_data        <= reg_wdata;
               write_collision_flag <= 1'b0;
            end else begin
               write_collision_flag <= 1'b1;
            end
         end
         if (ctl_wr) begin
            acknowledge_enable <= reg_wdata[`BIT_ACK_EN];
            start_request      <= reg_wdata[`BIT_START_REQ];
            stop_request       <= reg_wdata[`BIT_STOP_REQ];
            interface_enable   <= reg_wdata[`BIT_ENABLE];
            interrupt_enable   <= reg_wdata[`BIT_INT_EN];
         end
         if (clear_req) begin
            interrupt_flag <= 1'b0;
            woke           <= 1'b0;
            if (reg_wdata[`BIT_START_REQ] && leaves_addressed(status))
               start_pend <= 1'b1;
         end
         if (arbitration_lost)
            lost_arb <= 1'b1;
         if (!interface_enable) begin
            state   <= S_IDLE;
            sda_low <= 1'b0;
            busy    <= 1'b0;
         end else if ((start_seen || stop_seen) && (state != S_START) &&
                      (state != S_ERR)) begin
            busy <= start_seen;
            cnt  <= 4'h0;
            if (in_frame && (cnt > 4'h1)) begin // A STOP follows one clock rise
               status         <= `ST_BUS_ERROR;
               interrupt_flag <= 1'b1;
               state          <= S_ERR;
               sda_low        <= 1'b0;
            end else if (state == S_RX) begin
               status         <= `ST_STOP_RESTART;
               interrupt_flag <= 1'b1;
               state          <= start_seen ? S_ADDR : S_IDLE;
            end else if (state != S_HOLD) begin
               // Monitoring goes on whatever the ack and interrupt enables say
               state <= start_seen ? S_ADDR : S_IDLE;
            end
            if (stop_seen)
               lost_arb <= 1'b0;
         end else begin
            case (state)
               S_IDLE: begin
                  if (start_pend && !busy) begin
                     state     <= S_START;
                     sda_low   <= 1'b1;
                     start_cnt <= 12'h000;
                  end
               end
               S_ADDR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && (cnt == 4'h8)) begin
                     cnt <= 4'h0;
                     // Address bytes never reach the data register
                     if (acknowledge_enable && (own_hit || gc_hit)) begin
                        sda_low <= 1'b1;
                        state   <= S_AACK;
                        is_gc   <= gc_hit;
                        is_tx   <= shreg[0] && !gc_hit;
                        woke    <= sleep_active;
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     sda_low        <= 1'b0;
                     interrupt_flag <= 1'b1;
                     state          <= S_HOLD;
                     lost_arb       <= 1'b0;
                     if (is_tx)
                        status <= lost_arb ? `ST_LOST_OWN_R : `ST_OWN_R;
                     else if (is_gc)
                        status <= lost_arb ? `ST_LOST_GC : `ST_GC;
                     else
                        status <= lost_arb ? `ST_LOST_OWN_W : `ST_OWN_W;
                  end
               end
               S_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && (cnt == 4'h8)) begin
                     two_wire_data <= shreg;
                     nack          <= !acknowledge_enable;
                     sda_low       <= acknowledge_enable;
                     state         <= S_RACK;
                  end
               end
               S_RACK: begin
                  if (scl_fall) begin
                     sda_low        <= 1'b0;
                     cnt            <= 4'h0;
                     interrupt_flag <= 1'b1;
                     state          <= S_HOLD;
                     if (is_gc)
                        status <= nack ? `ST_GC_RX_NACK : `ST_GC_RX_ACK;
                     else
                        status <= nack ? `ST_RX_NACK : `ST_RX_ACK;
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (cnt == 4'h7) begin
                        sda_low <= 1'b0;
                        cnt     <= 4'h8;
                        state   <= S_TACK;
                     end else begin
                        shreg   <= {shreg[6:0], 1'b1};
                        sda_low <= !shreg[6];
                        cnt     <= cnt + 4'h1;
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     nack <= sda;
                  end else if (scl_fall) begin
                     cnt            <= 4'h0;
                     interrupt_flag <= 1'b1;
                     state          <= S_HOLD;
                     if (nack)
                        status <= `ST_TX_NACK;
                     else if (last)
                        status <= `ST_LAST_ACK;
                     else
                        status <= `ST_TX_ACK;
                  end
               end
               S_HOLD: begin
                  if (clear_req) begin
                     cnt <= 4'h0;
                     if (leaves_addressed(status)) begin
                        // Lines stay released, so further clocks read ones
                        state <= S_IDLE;
                     end else if (is_tx) begin
                        // First bit goes out in the same cycle that the clock hold is released
                        shreg   <= two_wire_data;
                        sda_low <= !two_wire_data[7];
                        last    <= !reg_wdata[`BIT_ACK_EN];
                        state   <= S_TX;
                     end else begin
                        state <= S_RX;
                     end
                  end
               end
               S_ERR: begin
                  if (clear_req && reg_wdata[`BIT_STOP_REQ]) begin
                     stop_request <= 1'b0;
                     sda_low      <= 1'b0;
                     busy         <= 1'b0;
                     state        <= S_IDLE;
                  end
               end
               S_START: begin
                  // Master logic elsewhere takes over after the hold time
                  if (start_cnt == START_HOLD_CYC - 1) begin
                     sda_low       <= 1'b0;
                     start_pend    <= 1'b0;
                     start_request <= 1'b0;
                     start_issued  <= 1'b1;
                     state         <= S_IDLE;
                  end else begin
                     start_cnt <= start_cnt + 12'h001;
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// file: tb/bus_master.sv
/*
 Behavioural two-wire bus master: START, STOP, byte write and byte read.
 Assumes the bench resolves both wires open drain with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_master #(
   parameter int QUARTER = 20
) (
   input  wire  scl,
   input  wire  sda,
   output logic scl_pull,
   output logic sda_pull
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   task automatic start();
      sda_pull = 1'b1;
      #(2*QUARTER) scl_pull = 1'b1;
      #QUARTER;
   endtask

   // Clock moves only inside a frame; the high phase waits out any stretch
   task automatic xbit(input logic v, output logic s);
      #QUARTER sda_pull = !v;
      #QUARTER scl_pull = 1'b0;
      wait (scl);
      #QUARTER s = sda;
      #QUARTER scl_pull = 1'b1;
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) xbit(b[i], s);
      xbit(1'b1, s);
      ack = !s;
   endtask

   task automatic rbyte(input logic give_ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
      xbit(!give_ack, s);
   endtask

   task automatic stop();
      #QUARTER sda_pull = 1'b1;
      #QUARTER scl_pull = 1'b0;
      wait (scl);
      #(2*QUARTER) sda_pull = 1'b0;
      #(2*QUARTER);
   endtask
endmodule

`default_nettype wire

// file: tb/two_wire_slave_engine_chk.sv
/*
 Checker for the two-wire slave engine: clock stretch, wake-up, START request.
 Assumes it sees only the engine's ports and is bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_consts.vh"

module two_wire_slave_engine_chk (
   input wire       clk,
   input wire       reset_n,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       scl_oe,
   input wire       sda_oe,
   input wire       sleep_active,
   input wire       wake_request,
   input wire       start_issued
);
   localparam int HOLD = `START_HOLD_NS * `CLK_MHZ / 1000;
   logic        ack_en;
   logic [15:0] hold_cnt;
   wire         ctl_wr = reg_wr && reg_addr == `OFS_CONTROL;
   wire         clear_wr = ctl_wr && reg_wdata[`BIT_FLAG];

   // Ack enable is only ever changed by software, so a write tracks it
   always @(posedge clk) begin
      if (!reset_n) begin
         ack_en <= 1'b0;
         hold_cnt <= 16'd0;
      end else begin
         if (ctl_wr) ack_en <= reg_wdata[`BIT_ACK_EN];
         hold_cnt <= sda_oe ? hold_cnt + 16'd1 : 16'd0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   stretch_release_a: assert property (scl_oe && clear_wr |=> !scl_oe)
      else $error("clock stretch kept after flag clear");
   stretch_hold_a: assert property (scl_oe && !ctl_wr |=> scl_oe)
      else $error("clock stretch dropped without clear");
   wake_cause_a: assert property ($rose(wake_request) |-> $past(sleep_active) && ack_en)
      else $error("wake without sleep or ack enable");
   wake_stretch_a: assert property (wake_request |-> scl_oe)
      else $error("clock not held during wake");
   wake_keep_a: assert property (wake_request && !clear_wr |=> wake_request)
      else $error("wake dropped early");
   wake_clear_a: assert property (wake_request && clear_wr |=> !wake_request)
      else $error("wake kept after clear");
   start_hold_a: assert property ($rose(start_issued) |->
      hold_cnt >= HOLD - 1 && hold_cnt <= HOLD + 1)
      else $error("start hold length wrong");
   start_pulse_a: assert property (start_issued |=> !start_issued)
      else $error("start pulse too long");
   start_release_a: assert property (start_issued |=> !sda_oe)
      else $error("data line held after start");

   cover property (start_issued);
   cover property ($rose(wake_request));
   cover property (scl_oe && clear_wr);
endmodule

bind two_wire_slave_engine two_wire_slave_engine_chk i_two_wire_slave_engine_chk (
   .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .scl_oe, .sda_oe, .sleep_active, .wake_request, .start_issued);

`default_nettype wire

// file: tb/test_two_wire_slave_engine.sv
/*
 Self-checking bench of the two-wire slave engine with a bus master model.
 Assumes the engine's header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_consts.vh"

module test_two_wire_slave_engine;
   localparam logic [7:0] OWN_RD = 8'h53;
   localparam logic [7:0] OWN_WR = 8'h52;
   logic       clk, reset_n, reg_wr, reg_rd, arbitration_lost, sleep_active, rd_pend, a;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, d, b;
   logic [7:0] exp_q[$];
   integer     err_total, n_checks, seed, i;
   wire  [7:0] reg_rdata;
   wire        scl_oe, sda_oe, m_scl, m_sda, wake_request, start_issued;
   wire        scl_w = !(scl_oe | m_scl);
   wire        sda_w = !(sda_oe | m_sda);

   two_wire_slave_engine i_two_wire_slave_engine (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .arbitration_lost(arbitration_lost),
      .sleep_active(sleep_active), .wake_request(wake_request),
      .start_issued(start_issued));
   bus_master i_bus_master (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      cmp({7'h00, got}, {7'h00, exp});
   endtask
   task end_of_test;
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input logic [2:0] ad, input logic [7:0] dt);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] ad, input logic [7:0] ex);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      exp_q.push_back(ex);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Status posts a few cycles after the clock falls on the bus
   task post(input logic [7:0] st);
      repeat (8) @(posedge clk);
      rd(`OFS_STATUS, st);
   endtask
   task sw_load(input logic [7:0] dt, input logic [7:0] ctl);
      wr(`OFS_DATA, dt);
      wr(`OFS_CONTROL, ctl);
   endtask
   task addr_byte(input logic [7:0] ab, input logic ex);
      i_bus_master.start();
      i_bus_master.wbyte(ab, a);
      chk_bit(a, ex);
   endtask
   task rx_byte(input logic ack, input logic [7:0] ex);
      i_bus_master.rbyte(ack, b);
      cmp(b, ex);
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_pend) cmp(reg_rdata, exp_q.pop_front());
      rd_pend <= reg_rd;
   end

   initial begin
      #400000;
      err_total = err_total + 1;
      end_of_test();
   end

   initial begin
      seed = 32'hcb8ad523;
      err_total = 0;
      n_checks = 0;
      rd_pend = 1'b0;
      reset_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      arbitration_lost = 1'b0;
      sleep_active = 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rd(`OFS_OWN_ADDR, `RST_OWN_ADDR);
      rd(`OFS_CONTROL, 8'h00);
      rd(`OFS_STATUS, `ST_NO_INFO);
      rd(`OFS_DATA, `RST_DATA);
      rd(3'h5, 8'h00);
      wr(`OFS_STATUS, 8'h03);
      rd(`OFS_STATUS, 8'hfb);
      wr(`OFS_STATUS, 8'h00);
      wr(`OFS_OWN_ADDR, OWN_RD);
      wr(`OFS_CONTROL, 8'h44);
      addr_byte(OWN_RD, 1'b1);
      post(`ST_OWN_R);
      d = 8'($random(seed));
      sw_load(d, 8'hc4);
      rx_byte(1'b1, d);
      post(`ST_TX_ACK);
      d = 8'($random(seed));
      sw_load(d, 8'h84);
      rx_byte(1'b1, d);
      post(`ST_LAST_ACK);
      wr(`OFS_CONTROL, 8'h84);
      rx_byte(1'b0, 8'hff);
      i_bus_master.stop();
      addr_byte(OWN_RD, 1'b0);
      i_bus_master.stop();
      wr(`OFS_CONTROL, 8'h44);
      @(posedge clk) arbitration_lost <= 1'b1;
      @(posedge clk) arbitration_lost <= 1'b0;
      addr_byte(OWN_RD, 1'b1);
      post(`ST_LOST_OWN_R);
      d = 8'($random(seed));
      sw_load(d, 8'h84);
      rx_byte(1'b0, d);
      post(`ST_TX_NACK);
      wr(`OFS_CONTROL, 8'hc4);
      i_bus_master.stop();
      addr_byte(8'h00, 1'b1);
      post(`ST_GC);
      wr(`OFS_CONTROL, 8'hc4);
      d = 8'($random(seed));
      i_bus_master.wbyte(d, a);
      chk_bit(a, 1'b1);
      post(`ST_GC_RX_ACK);
      rd(`OFS_DATA, d);
      wr(`OFS_CONTROL, 8'h84);
      i_bus_master.wbyte(~d, a);
      chk_bit(a, 1'b0);
      post(`ST_GC_RX_NACK);
      wr(`OFS_CONTROL, 8'hc4);
      i_bus_master.wbyte(d, a);
      chk_bit(a, 1'b0);
      i_bus_master.stop();
      wr(`OFS_OWN_ADDR, OWN_WR);
      addr_byte(8'h00, 1'b0);
      i_bus_master.stop();
      addr_byte(OWN_WR, 1'b1);
      post(`ST_OWN_W);
      wr(`OFS_CONTROL, 8'hc4);
      d = 8'($random(seed));
      i_bus_master.wbyte(d, a);
      post(`ST_RX_ACK);
      wr(`OFS_CONTROL, 8'hc4);
      i_bus_master.stop();
      post(`ST_STOP_RESTART);
      wr(`OFS_CONTROL, 8'he4);
      i = 0;
      while (start_issued !== 1'b1 && i < 600) begin
         @(negedge clk);
         i = i + 1;
      end
      chk_bit(start_issued, 1'b1);
      rd(`OFS_CONTROL, 8'h44);
      sleep_active <= 1'b1;
      addr_byte(OWN_WR, 1'b1);
      post(`ST_OWN_W);
      @(negedge clk);
      chk_bit(wake_request, 1'b1);
      chk_bit(scl_oe, 1'b1);
      rd(`OFS_DATA, d);
      sleep_active <= 1'b0;
      wr(`OFS_CONTROL, 8'hc4);
      @(negedge clk);
      chk_bit(wake_request, 1'b0);
      i_bus_master.stop();
      post(`ST_STOP_RESTART);
      wr(`OFS_CONTROL, 8'hc4);
      addr_byte(OWN_WR, 1'b1);
      post(`ST_OWN_W);
      wr(`OFS_CONTROL, 8'hc4);
      i_bus_master.xbit(1'b0, a);
      i_bus_master.stop();
      post(`ST_BUS_ERROR);
      wr(`OFS_CONTROL, 8'hd4);
      rd(`OFS_CONTROL, 8'h44);
      rd(`OFS_STATUS, `ST_NO_INFO);
      end_of_test();
   end
endmodule

`default_nettype wire
